// File: src/input_function_pkg.sv
/*
  Constants for the special input function block: register map, field
  layouts, reset values and enumerations.
  Assumes a 32-bit APB slave at 200 MHz, one clock, synchronous reset.
*/
package input_function_pkg;

  localparam int unsigned N_INPUTS  = 7;
  localparam int unsigned N_COUNTER = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_ROLE       = 8'h00;
  localparam logic [7:0] OFS_EDGE       = 8'h04;
  localparam logic [7:0] OFS_LATCH_SEL  = 8'h08;
  localparam logic [7:0] OFS_HSC_CFG    = 8'h0c;
  localparam logic [7:0] OFS_CTRL       = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] OFS_RING_MAX0  = 8'h20;
  localparam logic [7:0] OFS_LATCHED0   = 8'h40;
  localparam logic [7:0] OFS_ACTIVE     = 8'h60;

  // Input roles, two bits per input
  localparam logic [1:0] ROLE_NORMAL    = 2'h0;
  localparam logic [1:0] ROLE_QUICK     = 2'h1;
  localparam logic [1:0] ROLE_INTERRUPT = 2'h2;

  // Edge selection: 0 rising (default), 1 falling
  localparam logic EDGE_RISING = 1'b0;

  // Latch target codes, four bits per input
  localparam logic [3:0] LATCH_NONE     = 4'h0;
  localparam logic [3:0] LATCH_PULSE0   = 4'h1;
  localparam logic [3:0] LATCH_COUNTER0 = 4'h5;

  // Counter config, eight bits per counter
  localparam int unsigned HSC_ENABLE_BIT = 0;
  localparam int unsigned HSC_RING_BIT   = 2;
  localparam int unsigned HSC_SWONLY_BIT = 3;
  localparam int unsigned HSC_CONT_BIT   = 4;
  localparam int unsigned HSC_MODE_LSB   = 5;
  localparam logic [7:0]  HSC_CFG_RESET  = 8'h00;
  localparam logic [31:0] RING_MAX_RESET = 32'h0000_0000;
  localparam logic [31:0] RING_MAX_FULL  = 32'hffff_ffff;

  // Control register: bit 0 powers up, bit 1 starts operation
  localparam int unsigned CTRL_POWERUP_BIT = 0;
  localparam int unsigned CTRL_START_BIT   = 1;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b001,
    ST_STOPPED = 3'b010,
    ST_RUN     = 3'b100
  } op_state_t;

endpackage

// File: src/input_edge_cell.sv
/*
  One special input: two-flop synchroniser, edge detect by role and
  edge selection, filter bypass flag.
  Assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/10ps
module input_edge_cell
  import input_function_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Pin and settings
  input  wire logic       pin,
  input  wire logic [1:0] role,
  input  wire logic       edge_fall,
  // Results
  output logic            level,
  output logic            irq_edge,
  output logic            bypass_filter
);

  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  wire is_irq = (role == ROLE_INTERRUPT);
  wire rose   = sync & ~prev;
  wire fell   = ~sync & prev;

  assign level    = sync;
  // Edge selection counts only in interrupt role
  assign irq_edge = is_irq & (edge_fall ? fell : rose);
  assign bypass_filter = (role != ROLE_NORMAL);

endmodule

// File: src/input_function_edge_latch.sv
/*
  Special input function block: roles, interrupt edges, present value
  latch, counter default settings, ring wrap limit, APB register file.
  Assumes an APB master on mclk and pins asynchronous to mclk.
*/
`timescale 1ns/10ps
module input_function_edge_latch
  import input_function_pkg::*;
#(
  parameter int unsigned NI = N_INPUTS
)
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                srst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Special input pins
  input  wire logic [NI-1:0]       special_input,
  // Present values of pulse outputs and counters
  input  wire logic [4*32-1:0]     pulse_present_value,
  input  wire logic [4*32-1:0]     counter_present_value,
  // Results
  output logic [NI-1:0]            input_level,
  output logic [NI-1:0]            quick_input,
  output logic [NI-1:0]            filter_bypass,
  output logic [NI-1:0]            irq_event,
  output logic [4*8-1:0]           counter_cfg,
  output logic [4*32-1:0]          ring_limit,
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////
  // Staged settings written by software, applied on control events

  logic [2*NI-1:0]   role_stage;
  logic [NI-1:0]     edge_stage;
  logic [4*NI-1:0]   latch_stage;
  logic [2*NI-1:0]   role_act;
  logic [NI-1:0]     edge_act;
  logic [4*NI-1:0]   latch_act;
  logic [31:0]       hsc_stage;
  logic [31:0]       ring_max [N_COUNTER];
  logic [31:0]       latched  [N_COUNTER];
  logic [NI-1:0]     status;
  logic [NI-1:0]     enable;
  op_state_t         state;
  op_state_t         next_state;

  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & ~penable & ~pwrite;
  wire wr_ctrl = wr_acc & (paddr == OFS_CTRL);
  wire powerup = wr_ctrl & pwdata[CTRL_POWERUP_BIT];
  wire start   = wr_ctrl & pwdata[CTRL_START_BIT];
  wire wr_clr  = wr_acc & (paddr == OFS_IRQ_CLEAR);
  wire [2:0] ring_idx = paddr[4:2];
  wire wr_ring = wr_acc & (paddr[7:4] == OFS_RING_MAX0[7:4]);

  // Operation states: off until power-up, stopped until started
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:     if (powerup) next_state = ST_STOPPED;
      ST_STOPPED: if (start) next_state = ST_RUN;
      ST_RUN:     if (powerup) next_state = ST_STOPPED;
      default:    next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state       <= ST_OFF;
      role_stage  <= '0;
      edge_stage  <= '0;
      latch_stage <= '0;
      hsc_stage   <= {4{HSC_CFG_RESET}};
      enable      <= '0;
    end
    else
    begin
      state <= next_state;
      if (wr_acc && paddr == OFS_ROLE) role_stage <= pwdata[2*NI-1:0];
      if (wr_acc && paddr == OFS_EDGE) edge_stage <= pwdata[NI-1:0];
      if (wr_acc && paddr == OFS_LATCH_SEL)
        latch_stage <= pwdata[4*NI-1:0];
      if (wr_acc && paddr == OFS_HSC_CFG) hsc_stage <= pwdata;
      if (wr_acc && paddr == OFS_IRQ_ENABLE) enable <= pwdata[NI-1:0];
    end
  end

  // Roles, latch targets and counter setup load at power-up only;
  // the edge choice also reloads at every start
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      role_act    <= '0;
      latch_act   <= '0;
      edge_act    <= '0;
      counter_cfg <= {4{HSC_CFG_RESET}};
    end
    else
    begin
      if (powerup)
      begin
        role_act    <= role_stage;
        latch_act   <= latch_stage;
        counter_cfg <= hsc_stage;
      end
      if (powerup || start)
        edge_act <= edge_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ring limits: zero stands for the full 32-bit range

  genvar c;
  generate
    for (c = 0; c < N_COUNTER; c++)
    begin : g_ring
      always_ff @(posedge mclk)
      begin
        if (srst)
          ring_max[c] <= RING_MAX_RESET;
        else if (wr_ring && ring_idx == 3'(c))
          ring_max[c] <= pwdata;
      end
      always_ff @(posedge mclk)
      begin
        if (srst)
          ring_limit[32*c +: 32] <= RING_MAX_FULL;
        else if (powerup || start)
          ring_limit[32*c +: 32] <= (ring_max[c] == RING_MAX_RESET)
                                    ? RING_MAX_FULL : ring_max[c];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Per-input edge detection and latch capture

  wire [NI-1:0] lvl;
  wire [NI-1:0] edge_now;
  wire [NI-1:0] byp;
  wire          running = (state == ST_RUN);

  genvar i;
  generate
    for (i = 0; i < NI; i++)
    begin : g_in
      input_edge_cell u_cell (
        .mclk          (mclk),
        .srst          (srst),
        .pin           (special_input[i]),
        .role          (role_act[2*i +: 2]),
        .edge_fall     (edge_act[i]),
        .level         (lvl[i]),
        .irq_edge      (edge_now[i]),
        .bypass_filter (byp[i])
      );
    end
  endgenerate

  wire [NI-1:0] fire = edge_now & {NI{running}};

  // Lowest numbered firing input with a latch target wins the words
  logic [3:0] pick;
  logic       pick_ok;
  always_comb
  begin
    pick    = LATCH_NONE;
    pick_ok = 1'b0;
    for (int k = NI - 1; k >= 0; k--)
      if (fire[k] && latch_act[4*k +: 4] != LATCH_NONE)
      begin
        pick    = latch_act[4*k +: 4];
        pick_ok = 1'b1;
      end
  end

  wire [2:0]  slot = pick[2] ? 3'(pick - LATCH_COUNTER0)
                             : 3'(pick - LATCH_PULSE0);
  wire [31:0] cap  = (pick >= LATCH_COUNTER0)
                     ? counter_present_value[32*slot[1:0] +: 32]
                     : pulse_present_value[32*slot[1:0] +: 32];
  wire [1:0]  lslot = (pick >= LATCH_COUNTER0) ? slot[1:0] : slot[1:0];

  generate
    for (c = 0; c < N_COUNTER; c++)
    begin : g_lat
      always_ff @(posedge mclk)
      begin
        if (srst)
          latched[c] <= '0;
        else if (pick_ok && pick <= 4'h8 && lslot == 2'(c))
          latched[c] <= cap;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs, interrupt status, APB read

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      input_level   <= '0;
      quick_input   <= '0;
      filter_bypass <= '0;
      irq_event     <= '0;
      status        <= '0;
      irq           <= 1'b0;
    end
    else
    begin
      input_level   <= lvl;
      filter_bypass <= byp;
      for (int k = 0; k < NI; k++)
        quick_input[k] <= lvl[k] & (role_act[2*k +: 2] == ROLE_QUICK);
      irq_event <= fire;
      // Set wins over clear
      status <= (status & ~(wr_clr ? pwdata[NI-1:0] : '0)) | fire;
      irq    <= |(status & enable);
    end
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_ROLE:       rd_mux = 32'(role_stage);
      OFS_EDGE:       rd_mux = 32'(edge_stage);
      OFS_LATCH_SEL:  rd_mux = 32'(latch_stage);
      OFS_HSC_CFG:    rd_mux = hsc_stage;
      OFS_CTRL:       rd_mux = 32'(state);
      OFS_STATUS:     rd_mux = 32'(status);
      OFS_IRQ_ENABLE: rd_mux = 32'(enable);
      OFS_ACTIVE:     rd_mux = 32'({edge_act, role_act});
      default:
        if (paddr[7:4] == OFS_RING_MAX0[7:4])
          rd_mux = ring_max[paddr[3:2]];
        else if (paddr[7:4] == OFS_LATCHED0[7:4])
          rd_mux = latched[paddr[3:2]];
        else
          rd_mux = 32'h0000_0000;
    endcase
  end

  // No wait states: setup cycle captures read data, access completes in its first cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd_acc)
        prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_edge_gated;
    @(posedge mclk) disable iff (srst)
    irq_event[0] |-> $past(role_act[1:0]) == ROLE_INTERRUPT;
  endproperty
  a_edge_gated: assert property (p_edge_gated)
    else $error("interrupt event on a non-interrupt input");

  property p_role_default;
    @(posedge mclk) $fell(srst) |-> role_act == '0 && latch_act == '0;
  endproperty
  a_role_default: assert property (p_role_default)
    else $error("roles not normal after reset");

  property p_role_hold;
    @(posedge mclk) disable iff (srst)
    !$past(powerup) |-> $stable(role_act);
  endproperty
  a_role_hold: assert property (p_role_hold)
    else $error("role changed without power-up");

  property p_edge_reload;
    @(posedge mclk) disable iff (srst)
    start |=> edge_act == $past(edge_stage);
  endproperty
  a_edge_reload: assert property (p_edge_reload)
    else $error("edge choice not reloaded on start");

  property p_cfg_default;
    @(posedge mclk) $fell(srst) |-> counter_cfg == {4{HSC_CFG_RESET}};
  endproperty
  a_cfg_default: assert property (p_cfg_default)
    else $error("counter defaults wrong");

  property p_ring_zero;
    @(posedge mclk) disable iff (srst)
    start && ring_max[1] == '0 |=> ring_limit[63:32] == RING_MAX_FULL;
  endproperty
  a_ring_zero: assert property (p_ring_zero)
    else $error("zero ring maximum not widened");

  property p_bypass;
    @(posedge mclk) disable iff (srst)
    ##1 filter_bypass[0] == ($past(role_act[1:0]) != ROLE_NORMAL);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("filter bypass does not follow role");

  property p_latch_same;
    @(posedge mclk) disable iff (srst)
    fire[0] && latch_act[3:0] == LATCH_COUNTER0
      |=> latched[0] == $past(counter_present_value[31:0]);
  endproperty
  a_latch_same: assert property (p_latch_same)
    else $error("latched value not from the edge cycle");

  property p_irq;
    @(posedge mclk) disable iff (srst)
    irq_event[0] && enable[0] |-> ##[1:2] irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event did not raise interrupt");

endmodule

// File: dv/sensor_model.sv
/*
  Sensor model driving the special input pins.
  Assumes the bench sets wanted levels just after mclk rising edges.
*/
`timescale 1ns/10ps
module sensor_model
  import input_function_pkg::*;
(
  // Clock
  input  wire logic                mclk,
  // Bench control
  input  wire logic [N_INPUTS-1:0] want,
  input  wire logic                slow,
  // Pins
  output logic [N_INPUTS-1:0]      pins
);
  logic [N_INPUTS-1:0] lag1;
  logic [N_INPUTS-1:0] lag2;

  initial pins = '0;

  // Slow sensors settle two cycles late, as a sluggish contact would
  always @(posedge mclk)
  begin
    lag1 <= want;
    lag2 <= lag1;
    pins <= slow ? lag2 : want;
  end
endmodule

// File: dv/input_function_edge_latch_tb.sv
/*
  Self-checking bench for the special input function block.
  Assumes the design package and the sensor model are compiled first.
*/
`timescale 1ns/10ps
module input_function_edge_latch_tb
  import input_function_pkg::*;
;
  logic                mclk = 1'b0;
  logic                srst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic [N_INPUTS-1:0] pins;
  logic [N_INPUTS-1:0] want = '0;
  logic                slow = 1'b0;
  logic [31:0]         cnt = 32'h1000_0000;
  logic [127:0]        cpv;
  logic [127:0]        ppv;
  logic [127:0]        cpv_d;
  logic [127:0]        ppv_d;
  logic [N_INPUTS-1:0] irq_event;
  logic [N_INPUTS-1:0] filter_bypass;
  logic [N_INPUTS-1:0] quick_input;
  logic [N_INPUTS-1:0] input_level;
  logic [31:0]         counter_cfg;
  logic [127:0]        ring_limit;
  logic                irq;
  logic [31:0]         snap0;
  logic [31:0]         snap2;
  int                  evt [N_INPUTS];
  int                  mismatches = 0;
  int                  tests_run = 0;

  always #2.5 mclk = ~mclk;

  // Present values move every cycle so a late sample shows up
  always @(posedge mclk) cnt <= cnt + 32'h1;
  assign cpv = {cnt + 32'h3, cnt + 32'h2, cnt + 32'h1, cnt};
  assign ppv = cpv ^ {4{32'hffff_0000}};

  always @(posedge mclk)
  begin
    // Event shows a cycle after the edge; latch takes the edge cycle
    cpv_d <= cpv;
    ppv_d <= ppv;
    for (int i = 0; i < N_INPUTS; i++) evt[i] += irq_event[i];
    if (irq_event[0]) snap0 <= cpv_d[31:0];
    if (irq_event[2]) snap2 <= ppv_d[63:32];
  end

  sensor_model sens_u (.mclk(mclk), .want(want), .slow(slow), .pins(pins));

  input_function_edge_latch dut_u (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .special_input(pins),
    .pulse_present_value(ppv), .counter_present_value(cpv),
    .input_level(input_level), .quick_input(quick_input),
    .filter_bypass(filter_bypass), .irq_event(irq_event),
    .counter_cfg(counter_cfg), .ring_limit(ring_limit), .irq(irq));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic pins_to(input logic [N_INPUTS-1:0] w);
    want <= w;
    repeat (12) @(posedge mclk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    rd(OFS_ROLE, 32'h0);
    rd(OFS_EDGE, 32'h0);
    rd(OFS_LATCH_SEL, 32'h0);
    rd(OFS_HSC_CFG, {4{HSC_CFG_RESET}});
    rd(OFS_RING_MAX0, RING_MAX_RESET);
    rd(OFS_CTRL, 32'(ST_OFF));
    rd(8'h30, 32'h0);
    check(counter_cfg, 32'h0);
    check(ring_limit[31:0], RING_MAX_FULL);
    check(32'(filter_bypass), 32'h0);
  endtask

  task automatic configure();
    wr(OFS_ROLE, 32'h66);
    wr(OFS_EDGE, 32'h0c);
    // Counter 0 and pulse 1 only, a permitted pairing
    wr(OFS_LATCH_SEL, {20'h0, 4'h2, 4'h0, LATCH_COUNTER0});
    wr(OFS_HSC_CFG, 32'h05);
    wr(OFS_RING_MAX0, 32'h10);
    wr(OFS_IRQ_ENABLE, 32'h7f);
    #1 check(32'(filter_bypass), 32'h0);
    wr(OFS_CTRL, 32'h1);
    #1 check(counter_cfg, 32'h05);
    // Bypass flags are registered from the freshly loaded roles
    @(posedge mclk);
    #1 check(32'(filter_bypass), 32'h0f);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_CTRL, 32'(ST_RUN));
    check(ring_limit[31:0], 32'h10);
    check(ring_limit[63:32], RING_MAX_FULL);
    wr(OFS_ROLE, 32'h0);
    #1 check(32'(filter_bypass), 32'h0f);
  endtask

  task automatic edges_and_latch();
    pins_to(7'h04);
    check(32'(evt[2]), 32'h0);
    pins_to(7'h0f);
    check(32'(evt[0]), 32'h1);
    check(32'(evt[3]), 32'h0);
    check(32'(quick_input), 32'h0a);
    check(32'(irq), 32'h1);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_LATCHED0, snap0);
    pins_to(7'h02);
    check(32'(evt[0]), 32'h1);
    check(32'(evt[2]), 32'h1);
    check(32'(evt[3]), 32'h0);
    rd(OFS_STATUS, 32'h5);
    rd(OFS_LATCHED0 + 8'h4, snap2);
  endtask

  task automatic clear_and_mask();
    wr(OFS_IRQ_CLEAR, 32'h5);
    repeat (3) @(posedge mclk);
    #1 check(32'(irq), 32'h0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0);
    slow <= 1'b1;
    pins_to(7'h73);
    check(32'(input_level), 32'h73);
    check(32'(evt[0] + evt[4] + evt[5] + evt[6]), 32'h2);
    check(32'(irq), 32'h0);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_LATCHED0, snap0);
    wr(OFS_IRQ_ENABLE, 32'h7f);
    repeat (3) @(posedge mclk);
    #1 check(32'(irq), 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < N_INPUTS; i++) evt[i] = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    reset_values();
    configure();
    edges_and_latch();
    clear_and_mask();
    tally_and_finish();
  end
endmodule
